// ===== rtl/mie_consts.vh
`ifndef MIE_CONSTS_VH
`define MIE_CONSTS_VH

// ----------------------------------------------------------------------
// Operation codes from the decoder
// ----------------------------------------------------------------------
`define MIE_OP_W                      5
`define MIE_OP_MOVE_MEM_TO_ACC        5'h00
`define MIE_OP_MOVE_IMM_TO_ACC        5'h01
`define MIE_OP_MOVE_ACC_TO_MEM        5'h02
`define MIE_OP_NO_OPERATION           5'h03
`define MIE_OP_OR_MEM_TO_ACC          5'h04
`define MIE_OP_OR_IMM_TO_ACC          5'h05
`define MIE_OP_OR_INTO_MEMORY         5'h06
`define MIE_OP_SUBROUTINE_RETURN      5'h07
`define MIE_OP_RETURN_WITH_LITERAL    5'h08
`define MIE_OP_INTERRUPT_RETURN       5'h09
`define MIE_OP_ROTATE_LEFT_MEM        5'h0a
`define MIE_OP_ROTATE_LEFT_TO_ACC     5'h0b
`define MIE_OP_ROTATE_LEFT_THRU_CARRY 5'h0c
`define MIE_OP_ROTATE_LEFT_CARRY_ACC  5'h0d
`define MIE_OP_ROTATE_RIGHT_MEM       5'h0e
`define MIE_OP_ROTATE_RIGHT_TO_ACC    5'h0f
`define MIE_OP_ROTATE_RIGHT_THRU_CARRY 5'h10
`define MIE_OP_ROTATE_RIGHT_CARRY_ACC 5'h11
`define MIE_OP_SUB_WITH_BORROW_ACC    5'h12
`define MIE_OP_SUB_WITH_BORROW_MEM    5'h13
`define MIE_OP_DEC_SKIP_IF_ZERO       5'h14
`define MIE_OP_DEC_TO_ACC_SKIP_IF_ZERO 5'h15

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define MIE_RST_ACC                   8'h00
`define MIE_RST_FLAG                  1'h0
`define MIE_RST_IRQ_ENABLE            1'h0

// ----------------------------------------------------------------------
// Instruction cycle counts
// ----------------------------------------------------------------------
`define MIE_CYCLES_RETURN             2
`define MIE_CYCLES_SKIP_TAKEN         2
`define MIE_CYCLES_PLAIN              1

// ----------------------------------------------------------------------
// Bit positions
// ----------------------------------------------------------------------
`define MIE_BIT_MSB                   7
`define MIE_BIT_LSB                   0
`define MIE_BIT_NIBBLE                4

`endif

// ===== rtl/mie_exec_unit.v
`timescale 1ns/10ps
`default_nettype none
`include "mie_consts.vh"

module mie_exec_unit #(
  parameter PC_W = 12
) (
  input  wire            clk_sys,
  input  wire            sys_rst,
  input  wire            opValid,
  input  wire [4:0]      opCode,
  input  wire [7:0]      memData,
  input  wire [7:0]      immData,
  input  wire [PC_W-1:0] stackTop,
  input  wire            irqEnableClr,
  output wire            busy,
  output reg             opTaken,
  output reg  [7:0]      accQ,
  output reg             carryFlagQ,
  output reg             zeroFlagQ,
  output reg             halfCarryFlagQ,
  output reg             signedWrapFlagQ,
  output reg             globalIrqEnableQ,
  output reg             memWrQ,
  output reg  [7:0]      memWrDataQ,
  output reg  [PC_W-1:0] pcQ,
  output reg             stackPopQ,
  output reg             skipQ
);

  // --------------------------------------------------------------------
  // Sequencer states
  // --------------------------------------------------------------------
  localparam ST_RUN   = 1'b0;
  localparam ST_EXTRA = 1'b1;

  localparam [PC_W-1:0] PC_STEP = 1;

  reg stateQ;
  reg stateD;

  assign busy = stateQ;

  // --------------------------------------------------------------------
  // Acceptance: offers refused during a dummy cycle
  // --------------------------------------------------------------------
  reg take;

  always @* begin
    case (stateQ)
      ST_RUN: begin
        take = opValid;
      end
      ST_EXTRA: begin
        take = 1'b0;
      end
      default: begin
        take = 1'b0;
      end
    endcase
  end

  // --------------------------------------------------------------------
  // Datapath
  // --------------------------------------------------------------------
  wire [7:0] orRes;
  wire [7:0] rotLeft;
  wire [7:0] rotRight;
  wire [7:0] rotLeftC;
  wire [7:0] rotRightC;
  wire [7:0] decRes;
  wire [7:0] memInv;
  wire [8:0] subSum;
  wire [4:0] subLow;
  wire       subWrap;

  assign orRes     = accQ | memData;
  assign rotLeft   = {memData[6:0], memData[`MIE_BIT_MSB]};
  assign rotRight  = {memData[`MIE_BIT_LSB], memData[7:1]};
  assign rotLeftC  = {memData[6:0], carryFlagQ};
  assign rotRightC = {carryFlagQ, memData[7:1]};
  assign decRes    = memData - 8'h01;
  assign memInv    = ~memData;
  assign subSum    = {1'b0, accQ} + {1'b0, memInv} + {8'h00, carryFlagQ};
  assign subLow    = {1'b0, accQ[3:0]} + {1'b0, memInv[3:0]} + {4'h0, carryFlagQ};
  assign subWrap   = (accQ[`MIE_BIT_MSB] == memInv[`MIE_BIT_MSB]) &&
                     (subSum[`MIE_BIT_MSB] != accQ[`MIE_BIT_MSB]);

  // --------------------------------------------------------------------
  // Next-state decode
  // --------------------------------------------------------------------
  reg [7:0]      accD;
  reg            carryD;
  reg            zeroD;
  reg            halfD;
  reg            wrapD;
  reg            irqEnD;
  reg            memWrD;
  reg [7:0]      memWrDataD;
  reg [PC_W-1:0] pcD;
  reg            popD;
  reg            skipD;

  always @* begin
    accD       = accQ;
    carryD     = carryFlagQ;
    zeroD      = zeroFlagQ;
    halfD      = halfCarryFlagQ;
    wrapD      = signedWrapFlagQ;
    irqEnD     = globalIrqEnableQ;
    memWrD     = 1'b0;
    memWrDataD = memWrDataQ;
    pcD        = pcQ;
    popD       = 1'b0;
    skipD      = 1'b0;
    stateD     = ST_RUN;
    if (irqEnableClr) begin
      irqEnD = 1'b0;
    end
    if (take) begin
      pcD = pcQ + PC_STEP;
      case (opCode)
        `MIE_OP_MOVE_MEM_TO_ACC: begin
          accD = memData;
        end
        `MIE_OP_MOVE_IMM_TO_ACC: begin
          accD = immData;
        end
        `MIE_OP_MOVE_ACC_TO_MEM: begin
          memWrD     = 1'b1;
          memWrDataD = accQ;
        end
        `MIE_OP_NO_OPERATION: begin
          pcD = pcQ + PC_STEP;
        end
        `MIE_OP_OR_MEM_TO_ACC: begin
          accD  = orRes;
          zeroD = (orRes == 8'h00);
        end
        `MIE_OP_OR_IMM_TO_ACC: begin
          accD  = accQ | immData;
          zeroD = ((accQ | immData) == 8'h00);
        end
        `MIE_OP_OR_INTO_MEMORY: begin
          memWrD     = 1'b1;
          memWrDataD = orRes;
          zeroD      = (orRes == 8'h00);
        end
        `MIE_OP_SUBROUTINE_RETURN: begin
          pcD    = stackTop;
          popD   = 1'b1;
          stateD = ST_EXTRA;
        end
        `MIE_OP_RETURN_WITH_LITERAL: begin
          pcD    = stackTop;
          popD   = 1'b1;
          accD   = immData;
          stateD = ST_EXTRA;
        end
        `MIE_OP_INTERRUPT_RETURN: begin
          pcD    = stackTop;
          popD   = 1'b1;
          irqEnD = 1'b1;
          stateD = ST_EXTRA;
        end
        `MIE_OP_ROTATE_LEFT_MEM: begin
          memWrD     = 1'b1;
          memWrDataD = rotLeft;
        end
        `MIE_OP_ROTATE_LEFT_TO_ACC: begin
          accD = rotLeft;
        end
        `MIE_OP_ROTATE_LEFT_THRU_CARRY: begin
          memWrD     = 1'b1;
          memWrDataD = rotLeftC;
          carryD     = memData[`MIE_BIT_MSB];
        end
        `MIE_OP_ROTATE_LEFT_CARRY_ACC: begin
          accD   = rotLeftC;
          carryD = memData[`MIE_BIT_MSB];
        end
        `MIE_OP_ROTATE_RIGHT_MEM: begin
          memWrD     = 1'b1;
          memWrDataD = rotRight;
        end
        `MIE_OP_ROTATE_RIGHT_TO_ACC: begin
          accD = rotRight;
        end
        `MIE_OP_ROTATE_RIGHT_THRU_CARRY: begin
          memWrD     = 1'b1;
          memWrDataD = rotRightC;
          carryD     = memData[`MIE_BIT_LSB];
        end
        `MIE_OP_ROTATE_RIGHT_CARRY_ACC: begin
          accD   = rotRightC;
          carryD = memData[`MIE_BIT_LSB];
        end
        `MIE_OP_SUB_WITH_BORROW_ACC: begin
          accD   = subSum[7:0];
          carryD = subSum[8];
          halfD  = subLow[`MIE_BIT_NIBBLE];
          zeroD  = (subSum[7:0] == 8'h00);
          wrapD  = subWrap;
        end
        `MIE_OP_SUB_WITH_BORROW_MEM: begin
          memWrD     = 1'b1;
          memWrDataD = subSum[7:0];
          carryD     = subSum[8];
          halfD      = subLow[`MIE_BIT_NIBBLE];
          zeroD      = (subSum[7:0] == 8'h00);
          wrapD      = subWrap;
        end
        `MIE_OP_DEC_SKIP_IF_ZERO: begin
          memWrD     = 1'b1;
          memWrDataD = decRes;
          if (decRes == 8'h00) begin
            // Fetched successor dropped, dummy cycle follows
            pcD    = pcQ + PC_STEP + PC_STEP;
            skipD  = 1'b1;
            stateD = ST_EXTRA;
          end
        end
        `MIE_OP_DEC_TO_ACC_SKIP_IF_ZERO: begin
          accD = decRes;
          if (decRes == 8'h00) begin
            pcD    = pcQ + PC_STEP + PC_STEP;
            skipD  = 1'b1;
            stateD = ST_EXTRA;
          end
        end
        default: begin
          pcD = pcQ + PC_STEP;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------
  // Sequencer register
  // --------------------------------------------------------------------
  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      stateQ <= ST_RUN;
    end else begin
      stateQ <= stateD;
    end
  end

  // --------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------
  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      opTaken          <= 1'b0;
      accQ             <= `MIE_RST_ACC;
      carryFlagQ       <= `MIE_RST_FLAG;
      zeroFlagQ        <= `MIE_RST_FLAG;
      halfCarryFlagQ   <= `MIE_RST_FLAG;
      signedWrapFlagQ  <= `MIE_RST_FLAG;
      globalIrqEnableQ <= `MIE_RST_IRQ_ENABLE;
      memWrQ           <= 1'b0;
      memWrDataQ       <= 8'h00;
      pcQ              <= {PC_W{1'b0}};
      stackPopQ        <= 1'b0;
      skipQ            <= 1'b0;
    end else begin
      opTaken          <= take;
      accQ             <= accD;
      carryFlagQ       <= carryD;
      zeroFlagQ        <= zeroD;
      halfCarryFlagQ   <= halfD;
      signedWrapFlagQ  <= wrapD;
      globalIrqEnableQ <= irqEnD;
      memWrQ           <= memWrD;
      memWrDataQ       <= memWrDataD;
      pcQ              <= pcD;
      stackPopQ        <= popD;
      skipQ            <= skipD;
    end
  end

endmodule // mie_exec_unit

`default_nettype wire

// ===== test/mie_exec_unit_sva.sv
`timescale 1ns/10ps
`default_nettype none
`include "mie_consts.vh"
module mie_exec_unit_sva #(
  parameter PC_W = 12
) (
  input wire logic            clk_sys,
  input wire logic            sys_rst,
  input wire logic            opValid,
  input wire logic [4:0]      opCode,
  input wire logic [7:0]      memData,
  input wire logic [7:0]      immData,
  input wire logic [PC_W-1:0] stackTop,
  input wire logic            busy,
  input wire logic [7:0]      accQ,
  input wire logic            carryFlagQ,
  input wire logic            zeroFlagQ,
  input wire logic            halfCarryFlagQ,
  input wire logic            signedWrapFlagQ,
  input wire logic            globalIrqEnableQ,
  input wire logic            memWrQ,
  input wire logic [7:0]      memWrDataQ,
  input wire logic [PC_W-1:0] pcQ,
  input wire logic            stackPopQ,
  input wire logic            skipQ
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  wire       take = opValid & ~busy;
  // Status flags only: the interrupt enable also follows irqEnableClr
  wire [3:0] flg  = {carryFlagQ, zeroFlagQ, halfCarryFlagQ, signedWrapFlagQ};
  // ------------------------------------------------------------
  // Two-cycle instruction shapes
  // ------------------------------------------------------------
  sequence s_pop_two;
    stackPopQ && busy ##1 !busy && !stackPopQ;
  endsequence
  sequence s_skip_two;
    skipQ && busy ##1 !busy && !skipQ;
  endsequence
  property p_ret;
    take && opCode == `MIE_OP_SUBROUTINE_RETURN |=> (pcQ == $past(stackTop)) ##0 s_pop_two;
  endproperty
  property p_interrupt_return_op;
    take && opCode == `MIE_OP_INTERRUPT_RETURN |=> globalIrqEnableQ ##0 s_pop_two;
  endproperty
  property p_movi;
    take && opCode == `MIE_OP_MOVE_IMM_TO_ACC |=> accQ == $past(immData) && $stable(flg);
  endproperty
  property p_nop;
    take && opCode == `MIE_OP_NO_OPERATION |=>
      pcQ == PC_W'($past(pcQ) + 1) && $stable(accQ) && $stable(flg) && !memWrQ;
  endproperty
  property p_orm;
    take && opCode == `MIE_OP_OR_INTO_MEMORY |=> memWrQ &&
      memWrDataQ == ($past(accQ) | $past(memData)) && zeroFlagQ == (memWrDataQ == 8'h00);
  endproperty
  property p_rl;
    take && opCode == `MIE_OP_ROTATE_LEFT_MEM |=>
      memWrQ && {memWrDataQ[0], memWrDataQ[7:1]} == $past(memData) && $stable(flg);
  endproperty
  property p_rrc;
    take && opCode == `MIE_OP_ROTATE_RIGHT_THRU_CARRY |=>
      {memWrDataQ[6:0], carryFlagQ} == $past(memData) && memWrDataQ[7] == $past(carryFlagQ);
  endproperty
  property p_sdz_zero;
    take && opCode == `MIE_OP_DEC_SKIP_IF_ZERO && memData == 8'h01 |=>
      (memWrQ && memWrDataQ == 8'h00) ##0 s_skip_two;
  endproperty
  property p_sdz_nz;
    take && opCode == `MIE_OP_DEC_SKIP_IF_ZERO && memData != 8'h01 |=>
      !skipQ && !busy && memWrDataQ == $past(memData) - 8'h01;
  endproperty
  a_ret: assert property (p_ret) else $error("return pop wrong");
  a_interrupt_return_op: assert property (p_interrupt_return_op) else $error("irq return wrong");
  a_movi: assert property (p_movi) else $error("literal move wrong");
  a_nop: assert property (p_nop) else $error("no-op changed state");
  a_orm: assert property (p_orm) else $error("or to memory wrong");
  a_rl: assert property (p_rl) else $error("rotate left wrong");
  a_rrc: assert property (p_rrc) else $error("rotate right carry wrong");
  a_sdz_zero: assert property (p_sdz_zero) else $error("skip on zero wrong");
  a_sdz_nz: assert property (p_sdz_nz) else $error("decrement no skip wrong");
endmodule // mie_exec_unit_sva
`default_nettype wire

// ===== test/mie_exec_unit_test.sv
`timescale 1ns/10ps
`default_nettype none
module mie_exec_unit_test;
  localparam PC_W = 12;
  logic            clk_sys = 1'b0;
  logic            sys_rst, opValid, irqEnableClr;
  logic [4:0]      opCode;
  logic [7:0]      memData, immData, accQ, memWrDataQ, eAcc, eWd;
  logic [PC_W-1:0] stackTop, pcQ, ePc;
  logic            busy, opTaken, carryFlagQ, zeroFlagQ, halfCarryFlagQ, signedWrapFlagQ;
  logic            globalIrqEnableQ, memWrQ, stackPopQ, skipQ, eC, eZ, eH, eV, eIe;
  int              miscompares, checksDone, j;
  mie_exec_unit #(.PC_W(PC_W)) dut_u (.clk_sys, .sys_rst, .opValid, .opCode, .memData,
    .immData, .stackTop, .irqEnableClr, .busy, .opTaken, .accQ, .carryFlagQ, .zeroFlagQ,
    .halfCarryFlagQ, .signedWrapFlagQ, .globalIrqEnableQ, .memWrQ, .memWrDataQ, .pcQ,
    .stackPopQ, .skipQ);
  always #5 clk_sys = ~clk_sys;
  task chk(input logic [63:0] got, input logic [63:0] exp);
    checksDone++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task print_verdict;
    if (miscompares == 0 && checksDone > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // ------------------------------------------------------------
  // One instruction: reference model, drive, compare
  // ------------------------------------------------------------
  task exec(input logic [4:0] op, input logic [7:0] m, input logic [7:0] i);
    logic [8:0] t;
    logic [4:0] h;
    logic [7:0] r;
    logic       toAcc, toMem, ret, sk;
    t = {1'b0, eAcc} + {1'b0, ~m} + eC;
    h = {1'b0, eAcc[3:0]} + {1'b0, ~m[3:0]} + eC;
    case (op)
      5'h01, 5'h08: r = i;
      5'h02: r = eAcc;
      5'h04, 5'h06: r = eAcc | m;
      5'h05: r = eAcc | i;
      5'h0a, 5'h0b: r = {m[6:0], m[7]};
      5'h0c, 5'h0d: r = {m[6:0], eC};
      5'h0e, 5'h0f: r = {m[0], m[7:1]};
      5'h10, 5'h11: r = {eC, m[7:1]};
      5'h12, 5'h13: r = t[7:0];
      5'h14, 5'h15: r = m - 8'h01;
      default: r = m;
    endcase
    toAcc = op inside {5'h00, 5'h01, 5'h04, 5'h05, 5'h08, 5'h0b, 5'h0d, 5'h0f, 5'h11, 5'h12, 5'h15};
    toMem = op inside {5'h02, 5'h06, 5'h0a, 5'h0c, 5'h0e, 5'h10, 5'h13, 5'h14};
    ret = op inside {5'h07, 5'h08, 5'h09};
    sk = op inside {5'h14, 5'h15} && r == 8'h00;
    if (op inside {5'h04, 5'h05, 5'h06, 5'h12, 5'h13}) eZ = (r == 8'h00);
    if (op inside {5'h12, 5'h13}) begin
      eV = (eAcc[7] == ~m[7]) && (r[7] != eAcc[7]);
      eC = t[8];
      eH = h[4];
    end
    if (op inside {5'h0c, 5'h0d}) eC = m[7];
    if (op inside {5'h10, 5'h11}) eC = m[0];
    if (op == 5'h09) eIe = 1'b1;
    ePc = ret ? {4'ha, m} : ePc + (sk ? 12'h002 : 12'h001);
    if (toAcc) eAcc = r;
    if (toMem) eWd = r;
    @(posedge clk_sys);
    opValid <= 1'b1;
    opCode <= op;
    memData <= m;
    immData <= i;
    stackTop <= {4'ha, m};
    @(posedge clk_sys);
    opValid <= 1'b0;
    #1;
    chk({accQ, carryFlagQ, zeroFlagQ, halfCarryFlagQ, signedWrapFlagQ, globalIrqEnableQ, memWrQ,
      memWrDataQ, pcQ, stackPopQ, skipQ, busy, opTaken},
      {eAcc, eC, eZ, eH, eV, eIe, toMem, eWd, ePc, ret, sk, ret | sk, 1'b1});
    @(posedge clk_sys);
    #1;
    chk({opTaken, memWrQ, stackPopQ, skipQ, busy}, 5'h00);
  endtask
  initial begin
    sys_rst = 1'b1;
    {opValid, irqEnableClr, opCode, memData, immData, stackTop} = 35'h0;
    {eAcc, eWd, ePc, eC, eZ, eH, eV, eIe} = '0;
    repeat (8) @(posedge clk_sys);
    sys_rst <= 1'b0;
    #1;
    chk({accQ, pcQ, busy, opTaken, memWrQ}, 64'h0);
    exec(5'h01, 8'h00, 8'ha5);
    exec(5'h00, 8'h3c, 8'h00);
    exec(5'h02, 8'h00, 8'h00);
    exec(5'h03, 8'h55, 8'h55);
    exec(5'h04, 8'h41, 8'h00);
    exec(5'h01, 8'h00, 8'h00);
    exec(5'h05, 8'h00, 8'h00);
    exec(5'h06, 8'h80, 8'h00);
    exec(5'h06, 8'h00, 8'h00);
    for (j = 0; j < 16; j++) exec(5'h0a + j[2:0], j[3] ? 8'h6a : 8'h81, 8'h00);
    for (j = 0; j < 4; j++) begin
      exec(5'h01, 8'h00, 8'h50 + 8'h50 * j[7:0]);
      exec(5'h12 + j[0], 8'hb0 - 8'h3c * j[7:0], 8'h00);
    end
    exec(5'h07, 8'h13, 8'h00);
    exec(5'h08, 8'h27, 8'h9e);
    exec(5'h09, 8'h31, 8'h00);
    @(posedge clk_sys);
    irqEnableClr <= 1'b1;
    @(posedge clk_sys);
    irqEnableClr <= 1'b0;
    eIe = 1'b0;
    exec(5'h03, 8'h00, 8'h00);
    exec(5'h09, 8'h44, 8'h00);
    exec(5'h14, 8'h01, 8'h00);
    exec(5'h14, 8'h05, 8'h00);
    exec(5'h15, 8'h01, 8'h00);
    exec(5'h15, 8'h00, 8'h00);
    exec(5'h1f, 8'h77, 8'h77);
    print_verdict();
  end
endmodule // mie_exec_unit_test
bind mie_exec_unit mie_exec_unit_sva #(.PC_W(PC_W)) sva_u (.clk_sys, .sys_rst, .opValid,
  .opCode, .memData, .immData, .stackTop, .busy, .accQ, .carryFlagQ, .zeroFlagQ,
  .halfCarryFlagQ, .signedWrapFlagQ, .globalIrqEnableQ, .memWrQ, .memWrDataQ, .pcQ,
  .stackPopQ, .skipQ);
`default_nettype wire
